//--- common/cpl_credit_pkg.sv
// constants and types for the completion credit tracker
// assumes one user clock domain shared with the endpoint core's request and completion streams
package cpl_credit_pkg;
  localparam int ADDR_W = 12;
  localparam int LEN_W = 13;
  localparam int TAG_W = 8;
  localparam int HDR_W = 8;
  localparam int DATA_W = 12;
  localparam int BLOCK_BYTES = 16;
  localparam int BLOCK_SHIFT = 4;
  localparam int RCB_SMALL_BYTES = 64;
  localparam int RCB_LARGE_BYTES = 128;
  localparam int RCB_SMALL_SHIFT = 6;
  localparam int RCB_LARGE_SHIFT = 7;
  localparam int DW_BYTES = 4;
  localparam int QW_BYTES = 8;
  localparam logic [1:0] SCALE_BLOCK = 2'h0;
  localparam logic [1:0] SCALE_QW = 2'h1;
  localparam logic [1:0] SCALE_DW = 2'h2;
  localparam logic [HDR_W-1:0] HDR_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;

  typedef enum logic [1:0] {
    REQ_MEM_READ = 2'b00,
    REQ_IO_READ = 2'b01,
    REQ_IO_WRITE = 2'b10
  } req_type_t;

  typedef enum logic [1:0] {
    CPL_IDLE = 2'b00,
    CPL_DATA = 2'b01
  } cpl_state_t;
endpackage

//--- src/boundary_counter.sv
// ceiling-of-span counter: blocks touched by a byte span at a given address
// assumes the span length is at least one byte; pure combinational
`timescale 1ns/1ps
`default_nettype none
module boundary_counter
  import cpl_credit_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LEN_W-1:0] len,
  input wire logic [3:0] shift,
  output logic [LEN_W-1:0] blocks
);
  logic [LEN_W+ADDR_W-1:0] span;
  logic [LEN_W+ADDR_W-1:0] mask;
  logic [LEN_W+ADDR_W-1:0] offs;
  logic [LEN_W+ADDR_W-1:0] total;
  always_comb begin
    mask = ({(LEN_W+ADDR_W){1'b1}} << shift);
    offs = {{LEN_W{1'b0}}, addr} & ~mask;
    span = offs + {{ADDR_W{1'b0}}, len};
    // round up to whole blocks
    total = (span + ~mask) >> shift;
    blocks = total[LEN_W-1:0];
  end
endmodule
`default_nettype wire

//--- src/completion_credit_tracker.sv
// completion credit tracker, fine-grained data method with tag-based type policy
// assumes request and completion strobes are one-cycle pulses on MCLK from same-domain logic;
// the boundary select arrives from configuration status and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module completion_credit_tracker
  import cpl_credit_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic RCB_SELECT,
  input wire logic USE_RUNNING_ADDR,
  input wire logic [1:0] DATA_SCALE,
  input wire logic [HDR_W-1:0] HEADER_CREDIT_TOTAL,
  input wire logic [DATA_W-1:0] DATA_CREDIT_TOTAL,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_TYPE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [LEN_W-1:0] REQ_SIZE,
  input wire logic [TAG_W-1:0] REQ_TAG,
  input wire logic CPL_START,
  input wire logic [TAG_W-1:0] CPL_TAG,
  input wire logic [ADDR_W-1:0] CPL_LOWER_ADDR,
  input wire logic [LEN_W-1:0] CPL_LENGTH,
  input wire logic CPL_BEAT,
  input wire logic CPL_BEAT_QW,
  input wire logic CPL_END,
  output logic REQ_READY,
  output logic REQ_SENT,
  output logic [HDR_W-1:0] PENDING_HEADER,
  output logic [DATA_W-1:0] PENDING_DATA
);
  // ----------------------------------------------------------------
  // boundary select synchroniser
  // ----------------------------------------------------------------
  logic rcb_meta_r;
  logic rcb_sync_r;
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      rcb_meta_r <= 1'b0;
      rcb_sync_r <= 1'b0;
    end else if (CE) begin
      rcb_meta_r <= RCB_SELECT;
      rcb_sync_r <= rcb_meta_r;
    end
  end

  function automatic logic [3:0] rcb_shift(input logic sel);
    rcb_shift = sel ? 4'(RCB_LARGE_SHIFT) : 4'(RCB_SMALL_SHIFT);
  endfunction

  // data unit shift: 16-byte block, quadword or doubleword
  function automatic logic [3:0] unit_shift(input logic [1:0] scale);
    case (scale)
      SCALE_QW: unit_shift = 4'($clog2(QW_BYTES));
      SCALE_DW: unit_shift = 4'($clog2(DW_BYTES));
      default: unit_shift = 4'(BLOCK_SHIFT);
    endcase
  endfunction

  logic [3:0] hdr_shift;
  logic [3:0] dat_shift;
  assign hdr_shift = rcb_shift(rcb_sync_r);
  assign dat_shift = unit_shift(DATA_SCALE);

  // ----------------------------------------------------------------
  // request side need
  // ----------------------------------------------------------------
  logic [LEN_W-1:0] req_hdr_blocks;
  logic [LEN_W-1:0] req_dat_blocks;
  boundary_counter u_req_hdr (
    .addr(REQ_ADDR), .len(REQ_SIZE), .shift(hdr_shift), .blocks(req_hdr_blocks));
  boundary_counter u_req_dat (
    .addr(REQ_ADDR), .len(REQ_SIZE), .shift(dat_shift), .blocks(req_dat_blocks));

  logic [HDR_W:0] request_header_need;
  logic [DATA_W:0] request_data_need;
  always_comb begin
    request_header_need = (HDR_W+1)'(req_hdr_blocks);
    case (REQ_TYPE)
      // I/O read holds one data unit
      REQ_IO_READ: request_data_need = (DATA_W+1)'(1);
      REQ_IO_WRITE: request_data_need = '0;
      default: request_data_need = (DATA_W+1)'(req_dat_blocks);
    endcase
  end

  // ----------------------------------------------------------------
  // tag table
  // ----------------------------------------------------------------
  logic [1:0] tag_type_r [0:(1<<TAG_W)-1];
  logic [HDR_W-1:0] pending_header_credits_r;
  logic [DATA_W-1:0] pending_data_credits_r;
  logic [HDR_W:0] hdr_sum;
  logic [DATA_W:0] dat_sum;
  logic admit;
  assign hdr_sum = {1'b0, pending_header_credits_r} + request_header_need;
  assign dat_sum = {1'b0, pending_data_credits_r} + request_data_need;
  // strict credit check; failing request simply waits
  assign admit = REQ_VALID && (hdr_sum < {1'b0, HEADER_CREDIT_TOTAL})
                 && (dat_sum < {1'b0, DATA_CREDIT_TOTAL});

  always_ff @(posedge MCLK) begin
    if (CE && admit) begin
      tag_type_r[REQ_TAG] <= REQ_TYPE;
    end
  end

  // ----------------------------------------------------------------
  // completion side frees
  // ----------------------------------------------------------------
  logic [LEN_W-1:0] cpl_hdr_blocks;
  logic [LEN_W-1:0] cpl_dat_blocks;
  boundary_counter u_cpl_hdr (
    .addr(CPL_LOWER_ADDR), .len(CPL_LENGTH), .shift(hdr_shift), .blocks(cpl_hdr_blocks));
  boundary_counter u_cpl_dat (
    .addr(CPL_LOWER_ADDR), .len(CPL_LENGTH), .shift(dat_shift), .blocks(cpl_dat_blocks));

  logic [1:0] cpl_type;
  assign cpl_type = tag_type_r[CPL_TAG];

  // running address alternative
  cpl_state_t state_r;
  logic [ADDR_W-1:0] running_completion_address_r;
  logic [ADDR_W-1:0] run_next;
  logic [ADDR_W-1:0] step;
  logic hdr_roll;
  logic dat_roll;
  logic [ADDR_W-1:0] hdr_mask;
  logic [ADDR_W-1:0] dat_mask;
  always_comb begin
    step = CPL_BEAT_QW ? ADDR_W'(QW_BYTES) : ADDR_W'(DW_BYTES);
    run_next = running_completion_address_r + step;
    hdr_mask = ADDR_W'({ADDR_W{1'b1}} << hdr_shift);
    dat_mask = ADDR_W'({ADDR_W{1'b1}} << dat_shift);
    hdr_roll = ((run_next & hdr_mask) != (running_completion_address_r & hdr_mask));
    dat_roll = ((run_next & dat_mask) != (running_completion_address_r & dat_mask));
  end
  logic in_run;
  assign in_run = USE_RUNNING_ADDR && (state_r == CPL_DATA) && CPL_BEAT && !CPL_END;

  // load at start, advance per beat
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      state_r <= CPL_IDLE;
      running_completion_address_r <= '0;
    end else if (CE) begin
      case (state_r)
        CPL_IDLE: begin
          if (CPL_START && !CPL_END) begin
            state_r <= CPL_DATA;
            running_completion_address_r <= CPL_LOWER_ADDR;
          end
        end
        CPL_DATA: begin
          if (CPL_END) begin
            state_r <= CPL_IDLE;
          end else if (CPL_BEAT) begin
            running_completion_address_r <= run_next;
          end
        end
        default: state_r <= CPL_IDLE;
      endcase
    end
  end

  logic [HDR_W:0] hdr_free;
  logic [DATA_W:0] dat_free;
  always_comb begin
    hdr_free = '0;
    dat_free = '0;
    if (CPL_START) begin
      // header freed at start (and per crossing when computed)
      hdr_free = USE_RUNNING_ADDR ? (HDR_W+1)'(1) : (HDR_W+1)'(cpl_hdr_blocks);
      // data freed at start (and per data unit when computed)
      if (cpl_type == REQ_IO_WRITE) begin
        dat_free = '0;
      end else if (cpl_type == REQ_IO_READ) begin
        dat_free = (DATA_W+1)'(1);
      end else begin
        dat_free = USE_RUNNING_ADDR ? (DATA_W+1)'(1) : (DATA_W+1)'(cpl_dat_blocks);
      end
    end else if (in_run) begin
      // rollover not at end frees a header credit
      hdr_free = (HDR_W+1)'(hdr_roll);
      // data-unit rollover (16, 8 or 4 bytes per DATA_SCALE) frees a data unit for memory reads
      dat_free = (cpl_type == REQ_MEM_READ) ? (DATA_W+1)'(dat_roll) : '0;
    end
  end

  // ----------------------------------------------------------------
  // pending counters
  // ----------------------------------------------------------------
  logic [HDR_W+1:0] hdr_nxt;
  logic [DATA_W+1:0] dat_nxt;
  always_comb begin
    hdr_nxt = {1'b0, hdr_sum} - {1'b0, hdr_free};
    if (!admit) hdr_nxt = {2'b00, pending_header_credits_r} - {1'b0, hdr_free};
    dat_nxt = {1'b0, dat_sum} - {1'b0, dat_free};
    if (!admit) dat_nxt = {2'b00, pending_data_credits_r} - {1'b0, dat_free};
  end

  // counters cleared by reset; clamp at zero
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pending_header_credits_r <= HDR_ZERO;
      pending_data_credits_r <= DATA_ZERO;
    end else if (CE) begin
      pending_header_credits_r <= hdr_nxt[HDR_W+1] ? HDR_ZERO : hdr_nxt[HDR_W-1:0];
      pending_data_credits_r <= dat_nxt[DATA_W+1] ? DATA_ZERO : dat_nxt[DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      REQ_SENT <= 1'b0;
      REQ_READY <= 1'b0;
      PENDING_HEADER <= HDR_ZERO;
      PENDING_DATA <= DATA_ZERO;
    end else if (CE) begin
      REQ_SENT <= admit;
      REQ_READY <= admit;
      PENDING_HEADER <= pending_header_credits_r;
      PENDING_DATA <= pending_data_credits_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_CLEAR: assert property (@(posedge MCLK) !NRST |=>
    pending_header_credits_r == HDR_ZERO && pending_data_credits_r == DATA_ZERO)
    else $error("pending counters not cleared by reset");
  // header counter must land on pending plus need when nothing is freed, and stay below the total
  AST_ADMIT_LIMIT: assert property (@(posedge MCLK) disable iff (!NRST)
    CE && admit && hdr_free == '0
      |=> pending_header_credits_r == $past(hdr_sum[HDR_W-1:0])
        && pending_header_credits_r < HEADER_CREDIT_TOTAL)
    else $error("request admitted beyond header total");
  AST_HOLD_BACK: assert property (@(posedge MCLK) disable iff (!NRST)
    CE && REQ_VALID && !admit |=> !REQ_SENT)
    else $error("refused request reported sent");
  AST_SENT_FOLLOWS: assert property (@(posedge MCLK) disable iff (!NRST)
    CE && admit |=> REQ_SENT)
    else $error("admitted request not reported");
  AST_IOW_NODATA: assert property (@(posedge MCLK) disable iff (!NRST)
    REQ_TYPE == REQ_IO_WRITE |-> request_data_need == '0)
    else $error("io write given data need");
  AST_IOR_ONE: assert property (@(posedge MCLK) disable iff (!NRST)
    REQ_TYPE == REQ_IO_READ |-> request_data_need == (DATA_W+1)'(1))
    else $error("io read data need not one");
  AST_START_FREES: assert property (@(posedge MCLK) disable iff (!NRST)
    CPL_START |-> hdr_free != '0)
    else $error("completion start frees no header credit");
  sequence run_load_s;
    CE && state_r == CPL_IDLE && CPL_START && !CPL_END;
  endsequence
  AST_RUN_LOAD: assert property (@(posedge MCLK) disable iff (!NRST)
    run_load_s |=> running_completion_address_r == $past(CPL_LOWER_ADDR))
    else $error("running address not loaded");
endmodule
`default_nettype wire

//--- dv/cpl_stream_model.sv
// endpoint completion stream model: header fields at start, then 4-byte or 8-byte (qw) beats
// assumes the bench calls send one completion at a time; drives at falling edges
`timescale 1ns/1ps
`default_nettype none
module cpl_stream_model
  import cpl_credit_pkg::*;
(
  input wire logic MCLK,
  output logic CPL_START,
  output logic [TAG_W-1:0] CPL_TAG,
  output logic [ADDR_W-1:0] CPL_LOWER_ADDR,
  output logic [LEN_W-1:0] CPL_LENGTH,
  output logic CPL_BEAT,
  output logic CPL_BEAT_QW,
  output logic CPL_END
);
  initial begin
    {CPL_START, CPL_BEAT, CPL_BEAT_QW, CPL_END} = 4'h0;
    {CPL_TAG, CPL_LOWER_ADDR, CPL_LENGTH} = '0;
  end
  task automatic send(input logic [7:0] tag, input logic [11:0] la,
                      input logic [12:0] len, input logic qw, input int nbeat);
    @(negedge MCLK);
    CPL_START = 1'b1;
    CPL_BEAT_QW = qw;
    CPL_TAG = tag;
    CPL_LOWER_ADDR = la;
    CPL_LENGTH = len;
    CPL_END = (nbeat == 0);
    for (int k = 1; k <= nbeat; k++) begin
      @(negedge MCLK);
      CPL_START = 1'b0;
      CPL_BEAT = 1'b1;
      CPL_END = (k == nbeat);
    end
    @(negedge MCLK);
    // idle fields show the inverse so a stale value never matches
    {CPL_START, CPL_BEAT, CPL_END} = 3'h0;
    CPL_BEAT_QW = ~qw;
    CPL_TAG = ~tag;
    CPL_LOWER_ADDR = ~la;
    CPL_LENGTH = ~len;
  endtask
endmodule
`default_nettype wire

//--- dv/completion_credit_tracker_tb.sv
// self-checking bench: random requests and completions against a credit model
// assumes one clock; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
module completion_credit_tracker_tb
  import cpl_credit_pkg::*;
;
  logic MCLK, NRST, CE, RCB_SELECT, USE_RUNNING_ADDR, REQ_VALID;
  logic [1:0] DATA_SCALE, REQ_TYPE;
  logic [7:0] HEADER_CREDIT_TOTAL, REQ_TAG, CPL_TAG;
  logic [11:0] DATA_CREDIT_TOTAL, REQ_ADDR, CPL_LOWER_ADDR, PENDING_DATA;
  logic [12:0] REQ_SIZE, CPL_LENGTH;
  logic CPL_START, CPL_BEAT, CPL_BEAT_QW, CPL_END, REQ_READY, REQ_SENT;
  logic [7:0] PENDING_HEADER;
  logic [31:0] seed = 32'h1EA06305;
  int n_fail = 0, n_checks = 0, ph = 0, pd = 0, rcb, th, td, tdb, du = 16;
  logic qw = 1'b0;
  int a_t[256], n_t[256];
  logic [1:0] ty_t[256];
  logic [7:0] tq[$];

  completion_credit_tracker u_completion_credit_tracker (.MCLK(MCLK), .NRST(NRST), .CE(CE),
    .RCB_SELECT(RCB_SELECT), .USE_RUNNING_ADDR(USE_RUNNING_ADDR), .DATA_SCALE(DATA_SCALE),
    .HEADER_CREDIT_TOTAL(HEADER_CREDIT_TOTAL), .DATA_CREDIT_TOTAL(DATA_CREDIT_TOTAL),
    .REQ_VALID(REQ_VALID), .REQ_TYPE(REQ_TYPE), .REQ_ADDR(REQ_ADDR), .REQ_SIZE(REQ_SIZE),
    .REQ_TAG(REQ_TAG), .CPL_START(CPL_START), .CPL_TAG(CPL_TAG),
    .CPL_LOWER_ADDR(CPL_LOWER_ADDR), .CPL_LENGTH(CPL_LENGTH), .CPL_BEAT(CPL_BEAT),
    .CPL_BEAT_QW(CPL_BEAT_QW), .CPL_END(CPL_END), .REQ_READY(REQ_READY),
    .REQ_SENT(REQ_SENT), .PENDING_HEADER(PENDING_HEADER), .PENDING_DATA(PENDING_DATA));
  cpl_stream_model u_cpl_stream_model (.MCLK(MCLK), .CPL_START(CPL_START),
    .CPL_TAG(CPL_TAG), .CPL_LOWER_ADDR(CPL_LOWER_ADDR), .CPL_LENGTH(CPL_LENGTH),
    .CPL_BEAT(CPL_BEAT), .CPL_BEAT_QW(CPL_BEAT_QW), .CPL_END(CPL_END));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // blocks of u bytes touched by n bytes from address a
  function automatic int span(int a, int n, int u);
    return ((a % u) + n + u - 1) / u;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_pend();
    check({8'h00, PENDING_HEADER}, 16'(ph));
    check({4'h0, PENDING_DATA}, 16'(pd));
  endtask

  task automatic complete_one();
    logic [7:0] t;
    int fh, fd, bb;
    t = tq.pop_front();
    bb = qw ? 8 : 4;
    fh = span(a_t[t], n_t[t], rcb);
    fd = (ty_t[t] == REQ_IO_WRITE) ? 0 : (ty_t[t] == REQ_IO_READ) ? 1 : span(a_t[t], n_t[t], du);
    ph = (ph > fh) ? ph - fh : 0;
    pd = (pd > fd) ? pd - fd : 0;
    u_cpl_stream_model.send(t, 12'(a_t[t]), 13'(n_t[t]), qw,
                            (ty_t[t] == REQ_IO_WRITE) ? 0 : (n_t[t] + bb - 1) / bb);
  endtask
  task automatic watch(input int lim, output logic got);
    got = 1'b0;
    for (int k = 0; k < lim && !got; k++) begin
      @(negedge MCLK);
      got = (REQ_SENT === 1'b1);
    end
    check({15'h0, REQ_READY}, {15'h0, got});
    REQ_VALID = 1'b0;
  endtask

  task automatic request(input int i);
    logic [1:0] ty;
    int a, n, nh, nd;
    logic got, ok;
    ty = 2'(rnd() % 3);
    a = (ty != REQ_MEM_READ || USE_RUNNING_ADDR) ? rnd() & 32'hFFC : rnd() % 4096;
    if (qw) a = a & 32'hFF8;
    if (ty != REQ_MEM_READ) n = 4;
    else if (USE_RUNNING_ADDR) n = qw ? 8 * (1 + rnd() % 25) : 4 * (1 + rnd() % 50);
    else n = 1 + rnd() % 200;
    nh = span(a, n, rcb);
    nd = (ty == REQ_IO_WRITE) ? 0 : (ty == REQ_IO_READ) ? 1 : span(a, n, du);
    {REQ_TYPE, REQ_ADDR, REQ_SIZE, REQ_TAG} = {ty, 12'(a), 13'(n), 8'(i)};
    REQ_VALID = 1'b1;
    ok = (ph + nh < th) && (pd + nd < td);
    if (!ok && tq.size() > 0) begin
      // held request retried while a completion frees credit
      fork
        complete_one();
        watch(80, got);
      join
      ok = (ph + nh < th) && (pd + nd < td);
    end else begin
      watch(3, got);
    end
    check({15'h0, got}, {15'h0, ok});
    if (got) begin
      ph += nh;
      pd += nd;
      tq.push_back(8'(i));
      {a_t[i], n_t[i], ty_t[i]} = {a, n, ty};
    end
    @(negedge MCLK);
    check_pend();
  endtask

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  initial begin
    repeat (100000) @(posedge MCLK);
    n_fail++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    r = rnd();
    {NRST, CE, USE_RUNNING_ADDR, DATA_SCALE, REQ_VALID} = {1'b0, 1'b1, 1'b0, SCALE_BLOCK, 1'b0};
    {REQ_TYPE, REQ_ADDR, REQ_SIZE, REQ_TAG} = '0;
    RCB_SELECT = r[0];
    rcb = r[0] ? 128 : 64;
    th = 4 + (r >> 1) % 16;
    tdb = 8 + (r >> 5) % 64;
    td = tdb;
    HEADER_CREDIT_TOTAL = 8'(th);
    DATA_CREDIT_TOTAL = 12'(td);
    repeat (2) @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    check_pend();
    // clock enable low: an admissible request must not be taken
    {REQ_TYPE, REQ_ADDR, REQ_SIZE, REQ_TAG} = {REQ_MEM_READ, 12'h000, 13'h0004, 8'hFF};
    CE = 1'b0;
    REQ_VALID = 1'b1;
    repeat (3) @(negedge MCLK);
    check({15'h0, REQ_SENT}, 16'h0000);
    {CE, REQ_VALID} = 2'b10;
    @(negedge MCLK);
    check_pend();
    for (int i = 0; i < 200; i++) begin
      if (i % 50 == 0 && i > 0) begin
        // units change only with nothing outstanding
        while (tq.size() > 0) complete_one();
        USE_RUNNING_ADDR = (i >= 100);
        qw = (i == 150);
        du = (i == 50) ? 4 : (i == 100) ? 16 : 8;
        DATA_SCALE = (i == 50) ? SCALE_DW : (i == 100) ? SCALE_BLOCK : SCALE_QW;
        // data total scaled to the unit
        td = tdb * 16 / du;
        DATA_CREDIT_TOTAL = 12'(td);
      end
      if (i == 175) begin
        // reset in mid-run with credits outstanding
        NRST = 1'b0;
        repeat (2) @(negedge MCLK);
        NRST = 1'b1;
        tq.delete();
        ph = 0;
        pd = 0;
        repeat (3) @(negedge MCLK);
        check_pend();
      end
      request(i);
      if (rnd() % 3 == 0 && tq.size() > 0) begin
        complete_one();
        @(negedge MCLK);
        check_pend();
      end
    end
    while (tq.size() > 0) complete_one();
    @(negedge MCLK);
    check_pend();
    close_out();
  end
endmodule
`default_nettype wire
